// ---- common/iec_consts.svh ----
// Constants of the interrupt flag and enable controller and its CPU end.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IEC_CONSTS_SVH
`define IEC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map on the CPU memory bus
// ----------------------------------------------------------------------
`define IEC_ADDR_ENABLE   16'h000f
`define IEC_ADDR_FLAGS    16'h0010
`define IEC_ADDR_CLEAR    16'h0011

// ----------------------------------------------------------------------
// Bit positions in enable, flag and clear registers
// ----------------------------------------------------------------------
`define IEC_BIT_VSYNC     0
`define IEC_BIT_PIN       1
`define IEC_BIT_TIMER     2
`define IEC_BIT_ADDR      3
`define IEC_BIT_SHIFT     4
`define IEC_BIT_CLKLOW    5
`define IEC_BIT_VOV_CLR   6
`define IEC_BIT_HOV_CLR   7
`define IEC_NUM_SRC       6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IEC_RST_ENABLE    6'h00
`define IEC_RST_FLAGS     6'h00

// ----------------------------------------------------------------------
// Timer wrap and CPU entry constants
// ----------------------------------------------------------------------
`define IEC_TIMER_MAX     8'hff
`define IEC_TIMER_ZERO    8'h00
`define IEC_VEC_LO        16'hfffe
`define IEC_VEC_HI        16'hffff
`define IEC_STACK_PAGE    8'h01

`endif

// ---- common/iec_pkg.sv ----
// Types of the interrupt flag and enable controller and its CPU end.
// Assumes iec_consts.svh sits on the include path.
`include "iec_consts.svh"

package iec_pkg;

  // CPU end entry sequence, one-hot
  typedef enum logic [6:0] {
    IEC_IDLE    = 7'h01,
    IEC_PUSH_HI = 7'h02,
    IEC_PUSH_LO = 7'h04,
    IEC_PUSH_ST = 7'h08,
    IEC_VEC_LO  = 7'h10,
    IEC_VEC_HI  = 7'h20,
    IEC_LOAD    = 7'h40
  } iec_entry_type;

  // Whole state of the device end
  typedef struct packed {
    logic [5:0] enable;
    logic [5:0] flags;
    logic [7:0] rdata;
    logic       irq;
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic [2:0] pinPrev;
    logic [7:0] timerPrev;
    logic       horizClr;
    logic       vertClr;
  } iec_dev_type;

  // Whole state of the CPU end
  typedef struct packed {
    iec_entry_type state;
    logic          mask;
    logic [15:0]   pc;
    logic [7:0]    status;
    logic [7:0]    sp;
    logic [15:0]   addr;
    logic [7:0]    wdata;
    logic          wrStb;
    logic          rdStb;
    logic          swRdPend;
    logic [7:0]    swRdata;
    logic          swRdValid;
    logic [7:0]    vecLo;
    logic [15:0]   vector;
    logic          entryDone;
  } iec_cpu_type;

endpackage

// ---- common/iec_link_if.sv ----
// Memory bus and request line between CPU end and interrupt controller.
// Assumes both ends run on one clock that the bench supplies.
`timescale 1ns/10ps
`default_nettype none

interface iec_link_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wrStb;
  logic        rdStb;
  logic [7:0]  rdata;
  logic        irqReq;

  // Device end: register slave and request source
  modport dev (
    input  addr,
    input  wdata,
    input  wrStb,
    input  rdStb,
    output rdata,
    output irqReq
  );

  // CPU end: bus master and request sink
  modport cpu (
    output addr,
    output wdata,
    output wrStb,
    output rdStb,
    input  rdata,
    input  irqReq
  );
endinterface

`default_nettype wire

// ---- src/iec_irq_ctrl.sv ----
// Interrupt flag and enable controller: six event flags, enable mask,
// write-one clear, one request line to the CPU.
// Assumes one 10 MHz clock; pins arrive asynchronously, other events
// come from logic on the same clock.
//
// Functional notes
// - CPU finishes instruction, then checks mask
// - Unmasked: push PC and status, set mask
// - Then load PC from shared top vector
// - Vsync rising edge sets flag bit 0
// - Pin rising edge sets flag bit 1
// - Timer wrap to zero sets bit 2
// - Serial address match sets bit 3
// - Shift register event sets bit 4
// - Serial clock pulled low sets bit 5
// - Flags latch regardless of enable bits
// - Request when any flag and enable set
// - Flag holds until one written to clear
// - Reset clears enable and flag registers
// - Enable, flags, clear at consecutive addresses
// - Handler reads flags, clears before return
// - No hardware priority among sources
// - Upper clear bits reset sync counters
// - Clock-low flag on falling clock, transmit
`timescale 1ns/10ps
`default_nettype none
`include "iec_consts.svh"

module iec_irq_ctrl
  import iec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  iec_link_if.dev         link,
  input  wire logic       vsyncPin,
  input  wire logic       extIntPin,
  input  wire logic       sclPin,
  input  wire logic [7:0] timerCount,
  input  wire logic       addressMatchEvent,
  input  wire logic       shifterEvent,
  input  wire logic       ddc2TxMode,
  output logic            horizOverflowClear,
  output logic            vertOverflowClear,
  output logic [5:0]      flagView,
  output logic [5:0]      enableView
);

  // ----------------------------------------------------------------------
  // Local decoding
  // ----------------------------------------------------------------------

  // Full 16-bit compare: the three registers have no aliases
  // Address compare shared by write and read decode
  function automatic logic regHit(input logic [15:0] a, input logic [15:0] off);
    regHit = (a == off);
  endfunction

  // Pin index inside the synchroniser vectors
  localparam int PinVsync = 0;
  localparam int PinExt   = 1;
  localparam int PinScl   = 2;

  // One packed image of all state; the last comb block fills its copy
  iec_dev_type cur_ff;
  iec_dev_type nxt_cur;

  logic [5:0] events;
  logic [5:0] flagNext;
  logic [5:0] clearMask;
  logic [2:0] rising;
  logic [2:0] falling;
  logic       wrEnable;
  logic       wrClear;
  logic       rdFlags;

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------

  // Edges compare the second sync stage with the third, never the first
  always_comb begin
    rising  = cur_ff.pinSync & ~cur_ff.pinPrev;
    falling = ~cur_ff.pinSync & cur_ff.pinPrev;
    events  = '0;
    events[`IEC_BIT_VSYNC]  = rising[PinVsync];
    events[`IEC_BIT_PIN]    = rising[PinExt];
    // A preload that jumps past ff is not seen as a wrap
    // timer wrap detect
    events[`IEC_BIT_TIMER]  = (cur_ff.timerPrev == `IEC_TIMER_MAX) &&
                              (timerCount == `IEC_TIMER_ZERO);
    // Serial pulses come from this clock and last one cycle
    // address match
    events[`IEC_BIT_ADDR]   = addressMatchEvent;
    events[`IEC_BIT_SHIFT]  = shifterEvent;
    events[`IEC_BIT_CLKLOW] = falling[PinScl] && ddc2TxMode;
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------

  // Any other address decodes to nothing; writes there vanish
  // three consecutive registers
  always_comb begin
    wrEnable = link.wrStb && regHit(link.addr, `IEC_ADDR_ENABLE);
    wrClear  = link.wrStb && regHit(link.addr, `IEC_ADDR_CLEAR);
    rdFlags  = link.rdStb && regHit(link.addr, `IEC_ADDR_FLAGS);
    clearMask = wrClear ? link.wdata[5:0] : 6'h00;
  end

  // ----------------------------------------------------------------------
  // Flag cells
  // ----------------------------------------------------------------------

  // A clear written in the cycle of a fresh event keeps the flag set,
  // so software never loses an event it has not yet seen
  // latch ignores enables
  for (genvar g = 0; g < `IEC_NUM_SRC; g++) begin : g_flag
    assign flagNext[g] = events[g] | (cur_ff.flags[g] & ~clearMask[g]);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Single combinational image of the whole block state
  always_comb begin
    nxt_cur = cur_ff;

    // Third stage keeps the last settled level for edge detection
    // Pins: meta stage feeds sync stage only
    nxt_cur.pinMeta   = {sclPin, extIntPin, vsyncPin};
    nxt_cur.pinSync   = cur_ff.pinMeta;
    nxt_cur.pinPrev   = cur_ff.pinSync;
    nxt_cur.timerPrev = timerCount;

    // Write-only enable register; steers only the request
    if (wrEnable) begin
      nxt_cur.enable = link.wdata[5:0];
    end

    // Flag cells decide set and clear;
    // enables play no part in recording
    nxt_cur.flags = flagNext;

    nxt_cur.horizClr = wrClear && link.wdata[`IEC_BIT_HOV_CLR];
    nxt_cur.vertClr  = wrClear && link.wdata[`IEC_BIT_VOV_CLR];

    // upper flag bits zero
    // Write-only registers and unmapped addresses answer zero
    nxt_cur.rdata = rdFlags ? {2'b00, cur_ff.flags} : 8'h00;

    // Software picks the order of service among pending flags
    // plain OR, no priority
    // Registered from next values so a clear drops the request next cycle
    nxt_cur.irq = |(nxt_cur.flags & nxt_cur.enable);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Sync stages start low: a pin high at release reads as a rising edge
  // reset clears registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff.enable    <= `IEC_RST_ENABLE;
      cur_ff.flags     <= `IEC_RST_FLAGS;
      cur_ff.rdata     <= 8'h00;
      cur_ff.irq       <= 1'b0;
      cur_ff.pinMeta   <= 3'h0;
      cur_ff.pinSync   <= 3'h0;
      cur_ff.pinPrev   <= 3'h0;
      cur_ff.timerPrev <= 8'h00;
      cur_ff.horizClr  <= 1'b0;
      cur_ff.vertClr   <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from state
  // ----------------------------------------------------------------------

  // Request and read data onto the bus
  assign link.rdata         = cur_ff.rdata;
  assign link.irqReq        = cur_ff.irq;
  // Counter reset pulses toward the sync processor
  assign horizOverflowClear = cur_ff.horizClr;
  assign vertOverflowClear  = cur_ff.vertClr;
  // Software must shadow the enable value it wrote
  // Debug views; enable is not readable on the bus
  assign flagView           = cur_ff.flags;
  assign enableView         = cur_ff.enable;

endmodule

`default_nettype wire

// ---- src/iec_cpu_end.sv ----
// CPU end of the interrupt link: bus master for software accesses and
// the interrupt entry sequence (push PC and status, set mask, fetch vector).
// Assumes system memory outside answers vector reads on memRdata.
`timescale 1ns/10ps
`default_nettype none
`include "iec_consts.svh"

module iec_cpu_end
  import iec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  iec_link_if.cpu          link,
  input  wire logic        instrDone,
  input  wire logic [15:0] curPc,
  input  wire logic [7:0]  curStatus,
  input  wire logic [7:0]  curSp,
  input  wire logic        maskClear,
  input  wire logic [15:0] swAddr,
  input  wire logic [7:0]  swWdata,
  input  wire logic        swWr,
  input  wire logic        swRd,
  input  wire logic [7:0]  memRdata,
  output logic [7:0]       swRdata,
  output logic             swRdValid,
  output logic             busy,
  output logic             maskFlag,
  output logic [15:0]      vectorPc,
  output logic             entryDone
);

  iec_cpu_type cur_ff;
  iec_cpu_type nxt_cur;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Bus strobes are one cycle; software is refused while not idle
  always_comb begin
    nxt_cur           = cur_ff;
    nxt_cur.wrStb     = 1'b0;
    nxt_cur.rdStb     = 1'b0;
    // Device answers the cycle after its strobe; take it one cycle later
    nxt_cur.swRdPend  = cur_ff.rdStb && (cur_ff.state == IEC_IDLE);
    nxt_cur.swRdValid = 1'b0;
    nxt_cur.entryDone = 1'b0;
    // Read data follow the strobe by one cycle
    if (cur_ff.swRdPend) begin
      nxt_cur.swRdata   = link.rdata;
      nxt_cur.swRdValid = 1'b1;
    end
    case (cur_ff.state)
      IEC_IDLE: begin
        if (maskClear) begin
          nxt_cur.mask = 1'b0;
        end
        if (instrDone && link.irqReq && !cur_ff.mask) begin
          nxt_cur.pc     = curPc;
          nxt_cur.status = curStatus;
          nxt_cur.sp     = curSp;
          nxt_cur.state  = IEC_PUSH_HI;
        end else if (swWr) begin
          nxt_cur.addr  = swAddr;
          nxt_cur.wdata = swWdata;
          nxt_cur.wrStb = 1'b1;
        end else if (swRd) begin
          nxt_cur.addr     = swAddr;
          nxt_cur.rdStb    = 1'b1;
        end
      end
      IEC_PUSH_HI: begin
        nxt_cur.addr  = {`IEC_STACK_PAGE, cur_ff.sp};
        nxt_cur.wdata = cur_ff.pc[15:8];
        nxt_cur.wrStb = 1'b1;
        nxt_cur.sp    = cur_ff.sp - 8'h01;
        nxt_cur.state = IEC_PUSH_LO;
      end
      IEC_PUSH_LO: begin
        nxt_cur.addr  = {`IEC_STACK_PAGE, cur_ff.sp};
        nxt_cur.wdata = cur_ff.pc[7:0];
        nxt_cur.wrStb = 1'b1;
        nxt_cur.sp    = cur_ff.sp - 8'h01;
        nxt_cur.state = IEC_PUSH_ST;
      end
      IEC_PUSH_ST: begin
        nxt_cur.addr  = {`IEC_STACK_PAGE, cur_ff.sp};
        nxt_cur.wdata = cur_ff.status;
        nxt_cur.wrStb = 1'b1;
        nxt_cur.sp    = cur_ff.sp - 8'h01;
        nxt_cur.mask  = 1'b1;
        nxt_cur.state = IEC_VEC_LO;
      end
      IEC_VEC_LO: begin
        nxt_cur.addr  = `IEC_VEC_LO;
        nxt_cur.rdStb = 1'b1;
        nxt_cur.state = IEC_VEC_HI;
      end
      IEC_VEC_HI: begin
        nxt_cur.addr  = `IEC_VEC_HI;
        nxt_cur.rdStb = 1'b1;
        nxt_cur.vecLo = memRdata;
        nxt_cur.state = IEC_LOAD;
      end
      IEC_LOAD: begin
        nxt_cur.vector    = {memRdata, cur_ff.vecLo};
        nxt_cur.entryDone = 1'b1;
        nxt_cur.state     = IEC_IDLE;
      end
      default: begin
        nxt_cur.state = IEC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Mask set at reset, as after a chip reset sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff.state     <= IEC_IDLE;
      cur_ff.mask      <= 1'b1;
      cur_ff.pc        <= 16'h0000;
      cur_ff.status    <= 8'h00;
      cur_ff.sp        <= 8'h00;
      cur_ff.addr      <= 16'h0000;
      cur_ff.wdata     <= 8'h00;
      cur_ff.wrStb     <= 1'b0;
      cur_ff.rdStb     <= 1'b0;
      cur_ff.swRdPend  <= 1'b0;
      cur_ff.swRdata   <= 8'h00;
      cur_ff.swRdValid <= 1'b0;
      cur_ff.vecLo     <= 8'h00;
      cur_ff.vector    <= 16'h0000;
      cur_ff.entryDone <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign link.addr  = cur_ff.addr;
  assign link.wdata = cur_ff.wdata;
  assign link.wrStb = cur_ff.wrStb;
  assign link.rdStb = cur_ff.rdStb;
  assign swRdata    = cur_ff.swRdata;
  assign swRdValid  = cur_ff.swRdValid;
  assign busy       = (cur_ff.state != IEC_IDLE);
  assign maskFlag   = cur_ff.mask;
  assign vectorPc   = cur_ff.vector;
  assign entryDone  = cur_ff.entryDone;

endmodule

`default_nettype wire

// ---- tb/iec_link_sva.sv ----
// Checker of the link between CPU end and interrupt controller.
// Assumes the bench top instantiates it beside the link interface.
`timescale 1ns/10ps
`default_nettype none
`include "iec_consts.svh"

module iec_link_sva
  import iec_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [7:0]  rdata,
  input wire logic        irqReq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Two remaining pushes walk down the stack
  sequence s_pushRest;
    (wrStb && addr == $past(addr) - 16'h0001) [*2];
  endsequence
  // Shared vector fetched low byte first
  sequence s_vecFetch;
    rdStb && addr == `IEC_VEC_LO ##1 rdStb && addr == `IEC_VEC_HI;
  endsequence

  property p_rdOnlyAfterStb;
    rdata != 8'h00 |-> $past(rdStb);
  endproperty
  property p_flagsTopZero;
    rdStb && addr == `IEC_ADDR_FLAGS |=> rdata[7:6] == 2'b00;
  endproperty
  property p_woReadsZero;
    rdStb && addr != `IEC_ADDR_FLAGS |=> rdata == 8'h00;
  endproperty
  property p_oneStrobe;
    !(wrStb && rdStb);
  endproperty
  property p_enableOff;
    wrStb && addr == `IEC_ADDR_ENABLE && wdata[5:0] == 6'h00 |=> !irqReq;
  endproperty
  property p_resetQuiet;
    $rose(rst_n) |-> !irqReq && rdata == 8'h00;
  endproperty
  // First push only; a push after a software write is not caught
  property p_entrySeq;
    wrStb && addr[15:8] == `IEC_STACK_PAGE && !$past(wrStb) |=> s_pushRest ##1 s_vecFetch;
  endproperty
  property p_entryNeedsIrq;
    wrStb && addr[15:8] == `IEC_STACK_PAGE && !$past(wrStb) |-> $past(irqReq);
  endproperty

  a_rdOnlyAfterStb: assert property (p_rdOnlyAfterStb) else $error("read data outside slot");
  a_flagsTopZero: assert property (p_flagsTopZero) else $error("flag bits 7:6 not zero");
  a_woReadsZero: assert property (p_woReadsZero) else $error("write-only read nonzero");
  a_oneStrobe: assert property (p_oneStrobe) else $error("both strobes high");
  a_enableOff: assert property (p_enableOff) else $error("request with no enable");
  a_resetQuiet: assert property (p_resetQuiet) else $error("outputs busy after reset");
  a_entrySeq: assert property (p_entrySeq) else $error("entry sequence broken");
  a_entryNeedsIrq: assert property (p_entryNeedsIrq) else $error("entry without request");
endmodule

`default_nettype wire

// ---- tb/test_irq_flag_enable_controller.sv ----
// Bench for the interrupt controller facing the CPU end over the link.
// Assumes package, header and link interface compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "iec_consts.svh"

module test_irq_flag_enable_controller
  import iec_pkg::*;
;
  logic clk, rst_n, vsyncPin, extIntPin, sclPin, addressMatchEvent, shifterEvent;
  logic ddc2TxMode, horizOverflowClear, vertOverflowClear, instrDone, maskClear;
  logic swWr, swRd, swRdValid, busy, maskFlag, entryDone, sawH, sawV;
  logic [7:0] timerCount, curStatus, curSp, swWdata, memRdata, swRdata, m;
  logic [15:0] curPc, swAddr, vectorPc;
  logic [5:0] flagView, enableView;
  logic [23:0] pushed;
  int n_errors, num_checks, i, k;

  iec_link_if link ();

  iec_irq_ctrl i_iec_irq_ctrl (.clk(clk), .rst_n(rst_n), .link(link),
    .vsyncPin(vsyncPin), .extIntPin(extIntPin), .sclPin(sclPin),
    .timerCount(timerCount), .addressMatchEvent(addressMatchEvent),
    .shifterEvent(shifterEvent), .ddc2TxMode(ddc2TxMode),
    .horizOverflowClear(horizOverflowClear), .vertOverflowClear(vertOverflowClear),
    .flagView(flagView), .enableView(enableView));

  iec_cpu_end i_iec_cpu_end (.clk(clk), .rst_n(rst_n), .link(link),
    .instrDone(instrDone), .curPc(curPc), .curStatus(curStatus), .curSp(curSp),
    .maskClear(maskClear), .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr),
    .swRd(swRd), .memRdata(memRdata), .swRdata(swRdata), .swRdValid(swRdValid),
    .busy(busy), .maskFlag(maskFlag), .vectorPc(vectorPc), .entryDone(entryDone));

  iec_link_sva i_iec_link_sva (.clk(clk), .rst_n(rst_n), .addr(link.addr),
    .wdata(link.wdata), .wrStb(link.wrStb), .rdStb(link.rdStb),
    .rdata(link.rdata), .irqReq(link.irqReq));

  // ----------------------------------------------------------------
  // Clock, memory answer and pulse catchers
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  // Vector bytes 12/34, answered while the read strobe stands
  assign memRdata = (link.rdStb && link.addr == `IEC_VEC_HI) ? 8'h12 : 8'h34;

  // Pulse catchers and stack capture
  always @(posedge clk) begin
    if (horizOverflowClear === 1'b1) sawH <= 1'b1;
    if (vertOverflowClear === 1'b1) sawV <= 1'b1;
    if (link.wrStb === 1'b1 && link.addr[15:8] == `IEC_STACK_PAGE)
      pushed <= {pushed[15:0], link.wdata};
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Software write, then time for the flags to land
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
    for (i = 0; i < 8 && swRdValid !== 1'b1; i++) @(negedge clk);
    chk({what, " valid"}, 16'h0001, {15'h0, swRdValid});
    chk(what, {8'h00, exp}, {8'h00, swRdata});
  endtask

  // Pins are held past the two-stage synchroniser
  task automatic fire(input int s);
    @(posedge clk);
    case (s)
      0: vsyncPin <= 1'b1;
      1: extIntPin <= 1'b1;
      2: timerCount <= 8'hff;
      3: addressMatchEvent <= 1'b1;
      4: shifterEvent <= 1'b1;
      default: sclPin <= 1'b0;
    endcase
    @(posedge clk);
    addressMatchEvent <= 1'b0;
    shifterEvent <= 1'b0;
    timerCount <= 8'h00;
    repeat (4) @(posedge clk);
    vsyncPin <= 1'b0;
    extIntPin <= 1'b0;
    sclPin <= 1'b1;
    timerCount <= 8'h01;
    repeat (6) @(posedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rst_n = 0; vsyncPin = 0; extIntPin = 0; sclPin = 1; timerCount = 8'h01;
    addressMatchEvent = 0; shifterEvent = 0; ddc2TxMode = 1; instrDone = 0; maskClear = 0;
    curPc = 16'h4321; curStatus = 8'h20; curSp = 8'hff; swAddr = 0; swWdata = 0;
    swWr = 0; swRd = 0; pushed = 0; sawH = 0; sawV = 0; n_errors = 0; num_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("flagView", 16'h0, {10'h0, flagView});
    chk("enableView", 16'h0, {10'h0, enableView});
    chk("maskFlag", 16'h1, {15'h0, maskFlag});
    rd(`IEC_ADDR_FLAGS, 8'h00, "flags at reset");
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      m = 8'h01 << k;
      fire(k);
      rd(`IEC_ADDR_FLAGS, m, "flag latched");
      chk("irqReq masked", 16'h0, {15'h0, link.irqReq});
      wr(`IEC_ADDR_CLEAR, ~m & 8'h3f);
      rd(`IEC_ADDR_FLAGS, m, "flag after other clears");
      wr(`IEC_ADDR_CLEAR, m);
      rd(`IEC_ADDR_FLAGS, 8'h00, "flag cleared");
    end
    @(posedge clk);
    ddc2TxMode <= 1'b0;
    fire(5);
    rd(`IEC_ADDR_FLAGS, 8'h00, "clock low outside transmit");
    @(posedge clk);
    ddc2TxMode <= 1'b1;
    $display("test sources done");
    wr(`IEC_ADDR_ENABLE, 8'h11);
    chk("enableView", 16'h0011, {10'h0, enableView});
    fire(0);
    fire(4);
    chk("irqReq two pending", 16'h1, {15'h0, link.irqReq});
    rd(`IEC_ADDR_FLAGS, 8'h11, "both pending");
    wr(`IEC_ADDR_CLEAR, 8'h10);
    chk("irqReq one left", 16'h1, {15'h0, link.irqReq});
    wr(`IEC_ADDR_ENABLE, 8'h00);
    chk("irqReq disabled", 16'h0, {15'h0, link.irqReq});
    wr(`IEC_ADDR_CLEAR, 8'h01);
    $display("test request done");
    wr(`IEC_ADDR_FLAGS, 8'h3f);
    rd(`IEC_ADDR_FLAGS, 8'h00, "flags write ignored");
    rd(`IEC_ADDR_ENABLE, 8'h00, "enable write-only");
    rd(`IEC_ADDR_CLEAR, 8'h00, "clear write-only");
    rd(16'h0012, 8'h00, "unmapped read");
    chk("no early clear pulse", 16'h0, {14'h0, sawH, sawV});
    wr(`IEC_ADDR_CLEAR, 8'hc0);
    chk("horiz clear pulse", 16'h1, {15'h0, sawH});
    chk("vert clear pulse", 16'h1, {15'h0, sawV});
    $display("test map done");
    fire(4);
    @(posedge clk);
    swAddr <= `IEC_ADDR_CLEAR;
    swWdata <= 8'h10;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
    shifterEvent <= 1'b1;
    @(posedge clk);
    shifterEvent <= 1'b0;
    rd(`IEC_ADDR_FLAGS, 8'h10, "event beats clear");
    wr(`IEC_ADDR_CLEAR, 8'h10);
    $display("test collision done");
    wr(`IEC_ADDR_ENABLE, 8'h01);
    @(posedge clk);
    maskClear <= 1'b1;
    @(posedge clk);
    maskClear <= 1'b0;
    fire(0);
    @(posedge clk);
    instrDone <= 1'b1;
    @(posedge clk);
    instrDone <= 1'b0;
    @(negedge clk);
    chk("busy in entry", 16'h1, {15'h0, busy});
    for (i = 0; i < 12 && entryDone !== 1'b1; i++) @(negedge clk);
    chk("entryDone", 16'h1, {15'h0, entryDone});
    chk("vectorPc", 16'h1234, vectorPc);
    chk("maskFlag after entry", 16'h1, {15'h0, maskFlag});
    chk("pushed pc", 16'h4321, pushed[23:8]);
    chk("pushed status", 16'h0020, {8'h00, pushed[7:0]});
    @(posedge clk);
    instrDone <= 1'b1;
    @(posedge clk);
    instrDone <= 1'b0;
    @(negedge clk);
    chk("busy while masked", 16'h0, {15'h0, busy});
    rd(`IEC_ADDR_FLAGS, 8'h01, "handler source");
    wr(`IEC_ADDR_CLEAR, 8'h01);
    chk("irqReq after handler", 16'h0, {15'h0, link.irqReq});
    $display("test entry done");
    conclude();
  end
endmodule

`default_nettype wire
